// ==== core/ndac_core.sv ====
// Data EEPROM access controller: registers, sequencer, array and events
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// RL1 - Software loads index and byte value before starting a store.
// RL2 - Software sets store permit, then store trigger in the next instruction.
// RL3 - A store trigger without store permit starts no write cycle.
// RL4 - Store length comes from a timer asynchronous to the system clock.
// RL5 - Hardware clears store trigger when the write cycle ends.
// RL6 - Software masks global interrupts around starting a store.
// RL7 - Power-on reset clears store permit.
// RL8 - Power-on reset sets bank select to zero.
// RL9 - Control register is reached only while bank select points at bank one.
// RL10 - Write end sets the done flag and the shared interrupt flag.
// RL11 - Write-done interrupt needs its own enable and the shared enable.
// RL12 - Vector jump needs global, done and shared enables and a free stack.
// RL13 - Servicing clears only the shared flag; done flag waits for software.
// RL14 - No low-power entry until a fetch or store has fully completed.
// RL15 - Control bit 1 is fetch permit, bit 0 fetch trigger, polled to zero.
// RL16 - Control bit 3 is store permit, bit 2 store trigger, polled to zero.
// RL17 - Array of 64 bytes, 6-bit index, one byte per operation.
// RL18 - Fetch trigger without permit does nothing; hardware clears it after.
// RL19 - Fetched byte stays in the value register until the next operation.
// RL20 - Software never sets both triggers, nor all four bits at once.
// RL21 - While busy, new triggers, index and value writes are ignored.
module ndac_core (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       cpu_wr_en,
	input  wire logic       cpu_rd_en,
	input  wire logic [7:0] cpu_addr,
	input  wire logic [7:0] cpu_wdata,
	input  wire logic       global_irq_mask,
	input  wire logic       stack_full,
	input  wire logic       irq_serviced,
	input  wire logic       nv_timer_tick,
	output logic      [7:0] cpu_rdata_q,
	output logic            nv_busy_q,
	output logic            mf_vector_req_q,
	output logic      [1:0] bank_select_q
);

	// ****************************************************************
	// Decode
	// ****************************************************************
	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction

	ndac_pkg::ndac_ctrl_t  ctrl_q;
	ndac_pkg::ndac_irq_t   irq_q;
	ndac_pkg::ndac_state_t state_q;
	logic [5:0]            nv_byte_index_q;
	logic [7:0]            nv_byte_value_q;
	logic [7:0]            indirect_pointer_one_q;
	logic [2:0]            cnt_q;
	logic                  tick_s1_q;
	logic                  tick_s2_q;
	logic                  tick_s3_q;
	logic [7:0]            mem [ndac_pkg::DEPTH];

	wire logic       bank_one   = (bank_select_q == ndac_pkg::CTRL_BANK);
	wire logic [7:0] eff_addr   = hit(cpu_addr, ndac_pkg::IND_PORT_ADDR) ?
		indirect_pointer_one_q : cpu_addr;
	wire logic       ctrl_sel   = bank_one &&
		hit(eff_addr, ndac_pkg::CTRL_ADDR); // RL9
	wire logic       ctrl_wr    = cpu_wr_en && ctrl_sel;
	wire logic       idle       = (state_q == ndac_pkg::S_IDLE);
	wire logic [3:0] ctrl_bits  = ctrl_q;
	wire logic [3:0] irq_bits   = irq_q;
	wire logic       tick_pulse = tick_s2_q && !tick_s3_q;

	// Triggers act only against the permit already held, so a single
	// instruction setting permit and trigger together starts nothing.
	wire logic start_fetch = ctrl_wr && idle && ctrl_q.fetch_permit &&
		cpu_wdata[ndac_pkg::FETCH_TRIG_BIT]; // RL18
	wire logic start_store = ctrl_wr && idle && ctrl_q.store_permit &&
		cpu_wdata[ndac_pkg::STORE_TRIG_BIT] &&
		!cpu_wdata[ndac_pkg::FETCH_TRIG_BIT]; // RL3
	wire logic fetch_end = (state_q == ndac_pkg::S_FETCH) &&
		(cnt_q == 3'h0);
	wire logic store_end = (state_q == ndac_pkg::S_STORE) && tick_pulse &&
		(cnt_q == 3'h0); // RL4
	wire logic idx_wr  = cpu_wr_en && idle &&
		hit(eff_addr, ndac_pkg::INDEX_ADDR); // RL21
	wire logic val_wr  = cpu_wr_en && idle &&
		hit(eff_addr, ndac_pkg::VALUE_ADDR); // RL21
	wire logic irq_wr  = cpu_wr_en && hit(eff_addr, ndac_pkg::IRQ_ADDR);
	wire logic [7:0] mem_rd = mem[nv_byte_index_q]; // RL17

	wire logic [7:0] rd_mux =
		ctrl_sel ? {4'h0, ctrl_bits} :
		hit(eff_addr, ndac_pkg::INDEX_ADDR) ? {2'h0, nv_byte_index_q} :
		hit(eff_addr, ndac_pkg::VALUE_ADDR) ? nv_byte_value_q :
		hit(eff_addr, ndac_pkg::IRQ_ADDR) ? {4'h0, irq_bits} :
		hit(cpu_addr, ndac_pkg::PTR_ADDR) ? indirect_pointer_one_q :
		hit(cpu_addr, ndac_pkg::BANK_ADDR) ? {6'h00, bank_select_q} :
		8'h00;

	wire logic vector_d = irq_q.mf_irq_flag && irq_q.mf_irq_enable &&
		irq_q.nv_done_irq_enable && global_irq_mask && !stack_full; // RL12

	// ****************************************************************
	// Slow timer tick synchroniser
	// ****************************************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_s1_q <= 1'b0;
			tick_s2_q <= 1'b0;
			tick_s3_q <= 1'b0;
		end else begin
			tick_s1_q <= nv_timer_tick;
			tick_s2_q <= tick_s1_q;
			tick_s3_q <= tick_s2_q;
		end
	end

	// ****************************************************************
	// Pointer, bank, index and value registers
	// ****************************************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bank_select_q          <= ndac_pkg::BANK_RST; // RL8
			indirect_pointer_one_q <= ndac_pkg::BYTE_RST;
			nv_byte_index_q        <= 6'h00;
			nv_byte_value_q        <= ndac_pkg::BYTE_RST;
		end else begin
			if (cpu_wr_en && hit(cpu_addr, ndac_pkg::BANK_ADDR))
				bank_select_q <= cpu_wdata[1:0];
			if (cpu_wr_en && hit(cpu_addr, ndac_pkg::PTR_ADDR))
				indirect_pointer_one_q <= cpu_wdata;
			if (idx_wr)
				nv_byte_index_q <= cpu_wdata[5:0];
			if (fetch_end)
				nv_byte_value_q <= mem_rd; // RL19
			else if (val_wr)
				nv_byte_value_q <= cpu_wdata;
		end
	end

	// ****************************************************************
	// Sequencer and control register
	// ****************************************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ndac_pkg::S_IDLE;
			ctrl_q  <= '0; // RL7
			cnt_q   <= 3'h0;
		end else begin
			if (ctrl_wr) begin
				ctrl_q.store_permit <= cpu_wdata[ndac_pkg::STORE_PERMIT_BIT];
				ctrl_q.fetch_permit <= cpu_wdata[ndac_pkg::FETCH_PERMIT_BIT];
			end
			unique case (state_q)
				ndac_pkg::S_IDLE: begin
					if (start_fetch) begin
						state_q              <= ndac_pkg::S_FETCH;
						ctrl_q.fetch_trigger <= 1'b1; // RL15
						cnt_q                <= ndac_pkg::FETCH_CYCLES - 3'h1;
					end else if (start_store) begin
						state_q              <= ndac_pkg::S_STORE;
						ctrl_q.store_trigger <= 1'b1; // RL16
						cnt_q                <= ndac_pkg::STORE_TICKS - 3'h1;
					end
				end
				ndac_pkg::S_FETCH: begin
					if (fetch_end) begin
						state_q              <= ndac_pkg::S_IDLE;
						ctrl_q.fetch_trigger <= 1'b0; // RL18
					end else
						cnt_q <= cnt_q - 3'h1;
				end
				ndac_pkg::S_STORE: begin
					if (store_end) begin
						state_q              <= ndac_pkg::S_IDLE;
						ctrl_q.store_trigger <= 1'b0; // RL5
					end else if (tick_pulse)
						cnt_q <= cnt_q - 3'h1;
				end
			endcase
		end
	end

	// Array is nonvolatile: no reset, one byte per completed store
	always_ff @(posedge ref_clk) begin
		if (store_end)
			mem[nv_byte_index_q] <= nv_byte_value_q; // RL17
	end

	// ****************************************************************
	// Events, interrupt request and outputs
	// ****************************************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_q           <= '0;
			mf_vector_req_q <= 1'b0;
			nv_busy_q       <= 1'b0;
			cpu_rdata_q     <= ndac_pkg::BYTE_RST;
		end else begin
			if (irq_wr) begin
				irq_q.nv_done_irq_enable <= cpu_wdata[ndac_pkg::DONE_EN_BIT];
				irq_q.mf_irq_enable      <= cpu_wdata[ndac_pkg::MF_EN_BIT];
			end
			// A completing store beats a clear in the same cycle
			if (store_end)
				irq_q.nv_done_flag <= 1'b1; // RL10
			else if (irq_wr)
				irq_q.nv_done_flag <= cpu_wdata[ndac_pkg::DONE_FLAG_BIT];
			if (store_end)
				irq_q.mf_irq_flag <= 1'b1; // RL10
			else if (irq_serviced || irq_wr)
				irq_q.mf_irq_flag <= !irq_serviced &&
					cpu_wdata[ndac_pkg::MF_FLAG_BIT]; // RL13
			mf_vector_req_q <= vector_d && !irq_serviced; // RL11
			// Busy guards low-power entry; the core must wait on it
			nv_busy_q <= !(idle || fetch_end || store_end) ||
				start_fetch || start_store; // RL14
			if (cpu_rd_en)
				cpu_rdata_q <= rd_mux;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	chk_store_permit_gate: assert property (@(posedge ref_clk) // RL3
		disable iff (!rst_n) $rose(state_q == ndac_pkg::S_STORE) |->
		$past(ctrl_q.store_permit))
		else $error("store began without permit");

	chk_fetch_two_cycles: assert property (@(posedge ref_clk) // RL18
		disable iff (!rst_n) start_fetch |=>
		ctrl_q.fetch_trigger [*2] ##1 !ctrl_q.fetch_trigger)
		else $error("fetch length or trigger clear wrong");

	chk_store_end_flags: assert property (@(posedge ref_clk) // RL5
		disable iff (!rst_n) store_end |=>
		!ctrl_q.store_trigger && irq_q.nv_done_flag && irq_q.mf_irq_flag)
		else $error("store end did not clear trigger or set flags");

	chk_fetch_value: assert property (@(posedge ref_clk) // RL19
		disable iff (!rst_n) fetch_end |=> nv_byte_value_q == $past(mem_rd))
		else $error("fetched byte not loaded");

	chk_busy_index_hold: assert property (@(posedge ref_clk) // RL21
		disable iff (!rst_n) !idle |=>
		$stable(nv_byte_index_q) &&
		($stable(nv_byte_value_q) || $past(fetch_end)))
		else $error("index or value moved while busy");

	chk_vector_gate: assert property (@(posedge ref_clk) // RL12
		disable iff (!rst_n) mf_vector_req_q |->
		$past(global_irq_mask && !stack_full && irq_q.mf_irq_enable &&
		irq_q.nv_done_irq_enable))
		else $error("vector request without enables");

	chk_bank_zero_ctrl: assert property (@(posedge ref_clk) // RL9
		disable iff (!rst_n) cpu_wr_en && !bank_one && idle |=>
		$stable(ctrl_q))
		else $error("control changed from bank zero");

	chk_done_sticky: assert property (@(posedge ref_clk) // RL13
		disable iff (!rst_n) irq_q.nv_done_flag && !irq_wr |=>
		irq_q.nv_done_flag)
		else $error("done flag dropped without software");

	chk_busy_on_store: assert property (@(posedge ref_clk) // RL14
		disable iff (!rst_n) start_store |=> nv_busy_q)
		else $error("busy not raised on store");

endmodule
`default_nettype wire

// ==== core/ndac_pkg.sv ====
// Package for the data EEPROM access controller: map, fields and timing
package ndac_pkg;

	// ****************************************************************
	// Data-memory addresses of the block's registers
	// ****************************************************************
	localparam logic [7:0] IND_PORT_ADDR = 8'h02;
	localparam logic [7:0] PTR_ADDR      = 8'h03;
	localparam logic [7:0] BANK_ADDR  = 8'h04;
	localparam logic [7:0] INDEX_ADDR = 8'h2C;
	localparam logic [7:0] VALUE_ADDR = 8'h2D;
	localparam logic [7:0] IRQ_ADDR   = 8'h2E;
	localparam logic [7:0] CTRL_ADDR  = 8'h40;
	localparam logic [1:0] CTRL_BANK  = 2'h1;

	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int FETCH_TRIG_BIT   = 0;
	localparam int FETCH_PERMIT_BIT = 1;
	localparam int STORE_TRIG_BIT   = 2;
	localparam int STORE_PERMIT_BIT = 3;
	localparam int DONE_FLAG_BIT    = 0;
	localparam int DONE_EN_BIT      = 1;
	localparam int MF_FLAG_BIT      = 2;
	localparam int MF_EN_BIT        = 3;
	localparam int INDEX_W          = 6;
	localparam int DEPTH            = 64;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [1:0] BANK_RST = 2'h0;

	// ****************************************************************
	// Timing: fetch in system cycles, store in slow timer ticks
	// ****************************************************************
	localparam logic [2:0] FETCH_CYCLES = 3'h2;
	localparam logic [2:0] STORE_TICKS  = 3'h4;

	typedef struct packed {
		logic store_permit;
		logic store_trigger;
		logic fetch_permit;
		logic fetch_trigger;
	} ndac_ctrl_t;

	typedef struct packed {
		logic mf_irq_enable;
		logic mf_irq_flag;
		logic nv_done_irq_enable;
		logic nv_done_flag;
	} ndac_irq_t;

	typedef enum logic [1:0] {
		S_IDLE,
		S_FETCH,
		S_STORE
	} ndac_state_t;

endpackage

// ==== verification/ndac_tick_model.sv ====
// Slow timer model that paces the store cycle of the EEPROM controller
`timescale 1ns/1ns
`default_nettype none
module ndac_tick_model #(
	parameter int HALF_NS = 37
) (
	input  wire logic run,
	output var  logic nv_timer_tick
);
	// Period unrelated to ref_clk, so ticks land at five different clock phases
	initial begin
		nv_timer_tick = 1'b0;
		forever #(HALF_NS) nv_timer_tick = run ? ~nv_timer_tick : 1'b0;
	end
endmodule
`default_nettype wire

// ==== verification/data_eeprom_access_control_bench.sv ====
// Self-checking bench for the data EEPROM access controller
`timescale 1ns/1ns
`default_nettype none
module data_eeprom_access_control_bench;
	logic       ref_clk, rst_n, cpu_wr_en, cpu_rd_en, run, nv_timer_tick;
	logic [7:0] cpu_addr, cpu_wdata, cpu_rdata_q, v;
	logic       global_irq_mask, stack_full, irq_serviced;
	logic       nv_busy_q, mf_vector_req_q;
	logic [1:0] bank_select_q;
	int         n_errors, comparisons, cyc;
	logic [7:0] r_idx [3] = '{8'h00, 8'h3F, 8'h2A};
	logic [7:0] r_dat [3] = '{8'h5A, 8'hC3, 8'hFF};

	// ****************************************************************
	// Harness
	// ****************************************************************
	ndac_core uut (.ref_clk(ref_clk), .rst_n(rst_n), .cpu_wr_en(cpu_wr_en),
		.cpu_rd_en(cpu_rd_en), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
		.global_irq_mask(global_irq_mask), .stack_full(stack_full),
		.irq_serviced(irq_serviced), .nv_timer_tick(nv_timer_tick),
		.cpu_rdata_q(cpu_rdata_q), .nv_busy_q(nv_busy_q),
		.mf_vector_req_q(mf_vector_req_q), .bank_select_q(bank_select_q));
	ndac_tick_model tmr (.run(run), .nv_timer_tick(nv_timer_tick));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// Ceiling well above the few hundred cycles the sequence needs
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			n_errors++;
			tally_and_finish();
		end
	end

	task automatic cmp8(string what, logic [7:0] exp, logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		cpu_wr_en <= 1'b1;
		cpu_rd_en <= 1'b0;
		cpu_addr  <= a;
		cpu_wdata <= d;
		@(posedge ref_clk);
	endtask
	task automatic wc(logic [7:0] d);
		wr(ndac_pkg::IND_PORT_ADDR, d);
	endtask
	task automatic idle(int n);
		cpu_wr_en <= 1'b0;
		cpu_rd_en <= 1'b0;
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic rd(logic [7:0] a);
		cpu_wr_en <= 1'b0;
		cpu_rd_en <= 1'b1;
		cpu_addr  <= a;
		@(posedge ref_clk);
		cpu_rd_en <= 1'b0;
		@(posedge ref_clk);
		@(negedge ref_clk);
		v = cpu_rdata_q;
		@(posedge ref_clk);
	endtask
	task automatic busy_is(logic b);
		idle(1);
		@(negedge ref_clk);
		cmp8("busy", {7'h00, b}, {7'h00, nv_busy_q});
		@(posedge ref_clk);
	endtask
	task automatic poll(int b);
		int k;
		k = 0;
		v = 8'hFF;
		while (v[b] !== 1'b0 && k < 300) begin
			rd(ndac_pkg::IND_PORT_ADDR);
			k++;
		end
		cmp8("trigger clear", 8'h00, {7'h00, v[b]});
	endtask
	task automatic store(logic [7:0] a, logic [7:0] d);
		wr(ndac_pkg::INDEX_ADDR, a);
		wr(ndac_pkg::VALUE_ADDR, d);
		global_irq_mask <= 1'b0;
		wc(8'h08);
		wc(8'h0C);
		global_irq_mask <= 1'b1;
		busy_is(1'b1);
	endtask
	task automatic fetch(logic [7:0] a);
		wr(ndac_pkg::INDEX_ADDR, a);
		wc(8'h02);
		wc(8'h03);
		poll(0);
		rd(ndac_pkg::VALUE_ADDR);
	endtask
	task automatic reset_check;
		cmp8("bank", 8'h00, {6'h00, bank_select_q});
		wr(ndac_pkg::PTR_ADDR, 8'h40);
		wr(ndac_pkg::BANK_ADDR, 8'h01);
		rd(ndac_pkg::IND_PORT_ADDR);
		cmp8("ctrl reset", 8'h00, v);
		rd(ndac_pkg::VALUE_ADDR);
		cmp8("value reset", ndac_pkg::BYTE_RST, v);
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial begin
		rst_n = 1'b0;
		{cpu_wr_en, cpu_rd_en, stack_full, irq_serviced} = 4'h0;
		{cpu_addr, cpu_wdata} = 16'h0000;
		global_irq_mask = 1'b1;
		run = 1'b1;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		reset_check();
		for (int i = 0; i < 3; i++) begin
			wr(ndac_pkg::IRQ_ADDR, 8'h00);
			store(r_idx[i], r_dat[i]);
			poll(2);
			rd(ndac_pkg::IRQ_ADDR);
			cmp8("irq flags", 8'h05, v);
			rd(ndac_pkg::IND_PORT_ADDR);
			cmp8("ctrl after store", 8'h08, v);
			fetch(r_idx[i]);
			cmp8("fetched", r_dat[i], v);
		end
		// Control writes in bank 0 and triggers without an earlier permit
		wr(ndac_pkg::BANK_ADDR, 8'h00);
		wc(8'h08);
		wr(ndac_pkg::BANK_ADDR, 8'h01);
		rd(ndac_pkg::IND_PORT_ADDR);
		cmp8("ctrl from bank 0", 8'h02, v);
		wc(8'h00);
		wc(8'h04);
		wc(8'h01);
		wc(8'h0C);
		busy_is(1'b0);
		rd(ndac_pkg::IND_PORT_ADDR);
		cmp8("ctrl no permit", 8'h08, v);
		// Timer stalled: the store must wait and shield index and value
		run <= 1'b0;
		store(8'h05, 8'hA5);
		wr(ndac_pkg::INDEX_ADDR, 8'h3F);
		wr(ndac_pkg::VALUE_ADDR, 8'h11);
		idle(40);
		rd(ndac_pkg::IND_PORT_ADDR);
		cmp8("store waits", 8'h0C, v);
		rd(ndac_pkg::INDEX_ADDR);
		cmp8("index held", 8'h05, v);
		run <= 1'b1;
		poll(2);
		fetch(8'h05);
		cmp8("stored byte", 8'hA5, v);
		rd(ndac_pkg::IRQ_ADDR);
		rd(ndac_pkg::VALUE_ADDR);
		cmp8("value held", 8'hA5, v);
		// Vector gating by the done enable, the global mask, the stack and servicing
		wr(ndac_pkg::IRQ_ADDR, 8'h0D);
		idle(3);
		cmp8("vector", 8'h00, {7'h00, mf_vector_req_q});
		stack_full <= 1'b1;
		wr(ndac_pkg::IRQ_ADDR, 8'h0F);
		idle(3);
		cmp8("vector", 8'h00, {7'h00, mf_vector_req_q});
		{stack_full, global_irq_mask} <= 2'b00;
		idle(3);
		cmp8("vector", 8'h00, {7'h00, mf_vector_req_q});
		global_irq_mask <= 1'b1;
		idle(3);
		cmp8("vector", 8'h01, {7'h00, mf_vector_req_q});
		irq_serviced <= 1'b1;
		idle(1);
		irq_serviced <= 1'b0;
		rd(ndac_pkg::IRQ_ADDR);
		cmp8("irq after service", 8'h0B, v);
		cmp8("vector", 8'h00, {7'h00, mf_vector_req_q});
		rd(8'h10);
		cmp8("unmapped", 8'h00, v);
		rst_n <= 1'b0;
		idle(2);
		rst_n <= 1'b1;
		reset_check();
		tally_and_finish();
	end
endmodule
`default_nettype wire
